/* verilog/sebt_top.sv */
`timescale 1ns/1ps
module sebt_top import sebt_pkg::*; #(
    parameter logic [25:0] BURST_N = 26'(BURST_CYC),
    parameter logic [32:0] INTVL_N = 33'(INTVL_CYC),
    parameter logic [24:0] SOAK_N  = 25'(SOAK_CYC),
    parameter logic [24:0] HOLD_N  = 25'(HOLD_CYC)
) (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic [31:0] pat_data_i,
    input  wire logic        pat_vld_i,
    output logic             pat_rdy_o,
    input  wire logic        frame_en_i,
    input  wire logic        bist_lpbk_i,
    input  wire logic        bist_xmit_i,
    input  wire logic        oob_reset_i,
    input  wire logic        phy_rdy_i,
    input  wire logic        restart_expiry_i,
    input  wire logic [31:0] rx_word_i,
    input  wire logic [2:0]  rx_kind_i,
    input  wire logic        code_viol_i,
    input  wire logic        disp_err_i,
    input  wire logic        bit_err_i,
    output logic [31:0]      tx_word_o,
    output logic [2:0]       tx_kind_o,
    output logic             loop_o,
    output logic             xmit_o,
    output logic             thresh_o,
    output logic             holdoff_o,
    output logic [3:0]       tally_o,
    output logic [31:0]      byte_err_cnt_o,
    output logic             frame_err_o,
    output logic [15:0]      frame_err_cnt_o,
    output logic             soak_pass_o
);
    typedef struct packed {
        sebt_tx_e    st;
        sebt_tx_e    ret;
        logic [11:0] wcnt;
        logic [7:0]  gap;
        logic [31:0] txw;
        logic [2:0]  txk;
        logic        loop;
        logic        xmit;
        logic        phy;
        logic        win;
        logic [25:0] wcyc;
        logic [3:0]  tally;
        logic [32:0] icyc;
        logic        hold;
        logic [24:0] hcyc;
        logic        thr;
        logic [31:0] bcnt;
        logic [31:0] rprev;
        logic        rhave;
        logic        ferr;
        logic [15:0] fcnt;
        logic [24:0] scyc;
        logic        pass;
    } sebt_top_s;
    localparam sebt_top_s RST_S = '{st: TX_IDLE, ret: TX_IDLE, default: '0};

    sebt_top_s   s_q;
    sebt_top_s   s_d;
    logic [31:0] f_dat;
    logic        f_vld;
    logic        tx_pop;
    logic [31:0] tx_crc;
    logic [31:0] rx_crc;
    logic        ovr;
    logic        align_now;
    logic        err;
    logic        phy_rise;
    logic        rx_data;

    function automatic logic framed(sebt_tx_e st);
        return st inside {TX_SOF, TX_DATA, TX_CRC, TX_EOF, TX_ALIGN};
    endfunction

    // ****************************************************************
    // pattern buffer and crc engines
    // ****************************************************************
    sebt_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i    (clock_i),
        .rstn_i     (rstn_i),
        .in_data_i  (pat_data_i),
        .in_vld_i   (pat_vld_i),
        .in_rdy_o   (pat_rdy_o),
        .out_data_o (f_dat),
        .out_vld_o  (f_vld),
        .out_rdy_i  (tx_pop)
    );

    sebt_crc u_tx_crc (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .clr_i   (s_q.st == TX_SOF),
        .en_i    (tx_pop && s_q.st == TX_DATA),
        .data_i  (f_dat),
        .crc_o   (tx_crc)
    );

    // the crc trails the frame as its last data word, so the engine lags one word
    sebt_crc u_rx_crc (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .clr_i   (rx_kind_i == K_SOF),
        .en_i    (rx_data && s_q.rhave),
        .data_i  (s_q.rprev),
        .crc_o   (rx_crc)
    );

    assign ovr       = oob_reset_i || bist_lpbk_i || bist_xmit_i;
    assign align_now = framed(s_q.st) && s_q.gap == ALIGN_GAP;
    assign tx_pop    = !ovr && !align_now && f_vld && s_q.st inside {TX_DATA, TX_RAW};
    assign err       = code_viol_i || disp_err_i || bit_err_i;
    assign phy_rise  = phy_rdy_i && !s_q.phy;
    assign rx_data   = rx_kind_i == K_DATA;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d      = s_q;
        s_d.thr  = 1'b0;
        s_d.ferr = 1'b0;
        s_d.phy  = phy_rdy_i;

        // transmit side; only retimed loopback exists here
        if (oob_reset_i) begin
            s_d.st  = TX_IDLE;
            s_d.txk = K_IDLE;
            s_d.txw = '0;
        end else if (bist_lpbk_i) begin
            s_d.st = TX_LOOP;
        end else if (bist_xmit_i && s_q.st != TX_LOOP) begin
            s_d.st = TX_RAW;
        end else if (align_now) begin
            s_d.txk = K_ALIGN;
            s_d.ret = s_q.st;
            s_d.st  = TX_ALIGN;
            s_d.gap = '0;
        end else begin
            if (framed(s_q.st)) s_d.gap = s_q.gap + 8'h1;
            case (s_q.st)
                TX_IDLE: begin
                    s_d.txk = K_IDLE;
                    if (frame_en_i) s_d.st = TX_SOF;
                end
                TX_SOF: begin
                    s_d.txk  = K_SOF;
                    s_d.wcnt = '0;
                    s_d.st   = TX_DATA;
                end
                TX_DATA: begin
                    if (f_vld) begin
                        s_d.txw  = f_dat;
                        s_d.txk  = K_DATA;
                        s_d.wcnt = s_q.wcnt + 12'h1;
                        if (s_q.wcnt == MAX_WORDS - 12'h1) s_d.st = TX_CRC;
                    end else begin
                        s_d.txk = K_HOLD;
                    end
                end
                TX_CRC: begin
                    s_d.txw = tx_crc;
                    s_d.txk = K_CRC;
                    s_d.st  = TX_EOF;
                end
                TX_EOF: begin
                    s_d.txk = K_EOF;
                    s_d.st  = frame_en_i ? TX_SOF : TX_IDLE;
                end
                TX_ALIGN: begin
                    s_d.txk = K_ALIGN;
                    s_d.st  = s_q.ret;
                end
                TX_RAW: begin
                    s_d.txw = f_dat;
                    s_d.txk = f_vld ? K_DATA : K_IDLE;
                end
                TX_LOOP: begin
                    s_d.txw = rx_word_i;
                    s_d.txk = rx_kind_i;
                end
                default: begin
                    s_d.st = TX_IDLE;
                end
            endcase
        end
        s_d.loop = s_d.st == TX_LOOP;
        s_d.xmit = s_d.st == TX_RAW;

        // byte errors, saturating
        if (err && s_q.bcnt != '1) s_d.bcnt = s_q.bcnt + 32'h1;

        // burst window
        if (s_q.win) begin
            if (s_q.wcyc == BURST_N - 26'h1) begin
                s_d.win  = 1'b0;
                s_d.wcyc = '0;
            end else begin
                s_d.wcyc = s_q.wcyc + 26'h1;
            end
        end

        // burst tally, interval and holdoff
        if (phy_rise) begin
            s_d.tally = '0;
            s_d.icyc  = '0;
            s_d.hold  = 1'b0;
            s_d.hcyc  = '0;
            s_d.win   = 1'b0;
            s_d.wcyc  = '0;
        end else if (s_q.hold) begin
            if (s_q.hcyc == HOLD_N - 25'h1) begin
                s_d.hold  = 1'b0;
                s_d.hcyc  = '0;
                s_d.tally = '0;
                s_d.icyc  = '0;
            end else begin
                s_d.hcyc = s_q.hcyc + 25'h1;
            end
        end else begin
            if (s_q.icyc == INTVL_N - 33'h1) begin
                s_d.icyc = '0;
                if (restart_expiry_i) s_d.tally = '0;
            end else begin
                s_d.icyc = s_q.icyc + 33'h1;
            end
            if (err && !s_q.win) begin
                s_d.win  = 1'b1;
                s_d.wcyc = '0;
                if (s_q.tally == THRESH_CNT - 4'h1) begin
                    s_d.thr   = 1'b1;
                    s_d.hold  = 1'b1;
                    s_d.tally = '0;
                end else begin
                    s_d.tally = s_q.tally + 4'h1;
                end
            end
        end

        // receive frame crc check
        if (rx_kind_i == K_SOF) begin
            s_d.rhave = 1'b0;
        end else if (rx_data) begin
            s_d.rprev = rx_word_i;
            s_d.rhave = 1'b1;
        end else if (rx_kind_i == K_EOF) begin
            s_d.rhave = 1'b0;
            if (!s_q.rhave || rx_crc != s_q.rprev) begin
                s_d.ferr = 1'b1;
                if (s_q.fcnt != '1) s_d.fcnt = s_q.fcnt + 16'h1;
            end
        end

        // soak timer for loopback and framed runs
        if (!(framed(s_q.st) || s_q.st == TX_LOOP)) begin
            s_d.scyc = '0;
            s_d.pass = 1'b0;
        end else if (s_d.ferr) begin
            s_d.scyc = '0;
            s_d.pass = 1'b0;
        end else if (s_q.scyc == SOAK_N - 25'h1) begin
            s_d.pass = 1'b1;
        end else begin
            s_d.scyc = s_q.scyc + 25'h1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) s_q <= RST_S;
        else s_q <= s_d;
    end

    assign tx_word_o       = s_q.txw;
    assign tx_kind_o       = s_q.txk;
    assign loop_o          = s_q.loop;
    assign xmit_o          = s_q.xmit;
    assign thresh_o        = s_q.thr;
    assign holdoff_o       = s_q.hold;
    assign tally_o         = s_q.tally;
    assign byte_err_cnt_o  = s_q.bcnt;
    assign frame_err_o     = s_q.ferr;
    assign frame_err_cnt_o = s_q.fcnt;
    assign soak_pass_o     = s_q.pass;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_new_burst;
        err && !s_q.win && !s_q.hold && !phy_rise;
    endsequence
    sequence s_ins;
        align_now && !ovr ##1 !ovr;
    endsequence

    a_burst_open: assert property (s_new_burst |=>
        s_q.win && (s_q.thr || s_q.tally == $past(s_q.tally) + 4'h1))
        else $error("new burst not tallied");
    a_one_per_win: assert property (s_q.win && !s_q.hold && !phy_rise &&
        s_q.icyc != INTVL_N - 33'h1 |=> $stable(s_q.tally))
        else $error("tally moved inside burst window");
    a_win_len: assert property (s_q.win && !phy_rise && s_q.wcyc != BURST_N - 26'h1
        |=> s_q.win) else $error("burst window closed early");
    a_thresh_at: assert property (s_q.thr |-> $past(s_q.tally) == THRESH_CNT - 4'h1
        && s_q.tally == 4'h0 && s_q.hold) else $error("threshold at wrong tally");
    a_phy_restart: assert property (phy_rise |=> s_q.tally == 4'h0 &&
        !s_q.hold && s_q.icyc == 33'h0) else $error("no restart on ready");
    a_intvl_wrap: assert property (s_q.icyc == INTVL_N - 33'h1 && !s_q.hold &&
        !phy_rise |=> s_q.icyc == 33'h0) else $error("interval length wrong");
    a_byte_err: assert property (err && s_q.bcnt != '1 |=>
        s_q.bcnt == $past(s_q.bcnt) + 32'h1) else $error("byte error lost");
    a_crc_check: assert property (rx_kind_i == K_EOF && s_q.rhave &&
        rx_crc != s_q.rprev |=> s_q.ferr) else $error("bad crc not reported");
    a_frame_tail: assert property (s_q.st == TX_CRC && !ovr && !align_now |=>
        s_q.txk == K_CRC && s_q.txw == $past(tx_crc)) else $error("crc word missing");
    a_frame_len: assert property (s_q.st == TX_CRC |-> s_q.wcnt == MAX_WORDS)
        else $error("frame not at full length");
    a_align_pair: assert property (s_ins |=> s_q.txk == K_ALIGN &&
        $past(s_q.txk) == K_ALIGN) else $error("align pair broken");
    a_loop_entry: assert property (bist_lpbk_i && !oob_reset_i |=> loop_o)
        else $error("loopback not entered");
    a_loop_hold: assert property (loop_o && !oob_reset_i |=> loop_o)
        else $error("loopback left without oob reset");
    a_xmit_entry: assert property (bist_xmit_i && !bist_lpbk_i && !oob_reset_i
        && !loop_o |=> xmit_o) else $error("transmit mode not entered");
    a_soak_pass: assert property (s_q.pass |-> s_q.scyc == SOAK_N - 25'h1
        && !s_q.ferr) else $error("soak pass too early");
endmodule

/* include/sebt_pkg.sv */
// ****************************************************************
// timing, sizes and codes shared by the link test logic
// ****************************************************************
package sebt_pkg;
    localparam longint CLK_HZ    = 64'd25000000;
    localparam longint BURST_MS  = 64'd1500;
    localparam longint INTVL_S   = 64'd300;
    localparam longint SOAK_MS   = 64'd1000;
    localparam longint HOLD_MS   = 64'd1000;
    localparam longint BURST_CYC = BURST_MS * CLK_HZ / 64'd1000;
    localparam longint INTVL_CYC = INTVL_S * CLK_HZ;
    localparam longint SOAK_CYC  = SOAK_MS * CLK_HZ / 64'd1000;
    localparam longint HOLD_CYC  = HOLD_MS * CLK_HZ / 64'd1000;

    localparam logic [3:0]  THRESH_CNT = 4'hf;
    localparam int          WORD_W     = 32;
    localparam int          FIFO_DEPTH = 32;
    localparam logic [11:0] MAX_WORDS  = 12'h800;
    localparam logic [7:0]  ALIGN_GAP  = 8'hfe;
    localparam logic [31:0] CRC_POLY   = 32'h04c11db7;
    localparam logic [31:0] CRC_SEED   = 32'hffffffff;

    // word kinds on the transmit and receive word streams
    localparam logic [2:0] K_IDLE  = 3'h0;
    localparam logic [2:0] K_DATA  = 3'h1;
    localparam logic [2:0] K_SOF   = 3'h2;
    localparam logic [2:0] K_CRC   = 3'h3;
    localparam logic [2:0] K_EOF   = 3'h4;
    localparam logic [2:0] K_ALIGN = 3'h5;
    localparam logic [2:0] K_HOLD  = 3'h6;

    typedef enum logic [7:0] {
        TX_IDLE  = 8'h01,
        TX_SOF   = 8'h02,
        TX_DATA  = 8'h04,
        TX_CRC   = 8'h08,
        TX_EOF   = 8'h10,
        TX_ALIGN = 8'h20,
        TX_RAW   = 8'h40,
        TX_LOOP  = 8'h80
    } sebt_tx_e;
endpackage

/* verilog/sebt_fifo.sv */
`timescale 1ns/1ps
module sebt_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_vld_i,
    output logic                  in_rdy_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_vld_o,
    input  wire logic             out_rdy_i
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          rdy;
        logic          vld;
    } sebt_fifo_s;
    localparam sebt_fifo_s RST_S = '{rdy: 1'b1, default: '0};

    sebt_fifo_s       s_q;
    sebt_fifo_s       s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign push       = in_vld_i && s_q.rdy;
    assign pop        = out_rdy_i && s_q.vld;
    assign in_rdy_o   = s_q.rdy;
    assign out_vld_o  = s_q.vld;
    assign out_data_o = mem[s_q.rp];

    // depth must be a power of two so the pointers wrap by themselves
    always_comb begin
        s_d = s_q;
        if (push) s_d.wp = s_q.wp + AW'(1);
        if (pop) s_d.rp = s_q.rp + AW'(1);
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        s_d.rdy = s_d.cnt != (AW+1)'(DEPTH);
        s_d.vld = s_d.cnt != '0;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) s_q <= RST_S;
        else s_q <= s_d;
    end

    always_ff @(posedge clock_i) begin
        if (push) mem[s_q.wp] <= in_data_i;
    end
endmodule

/* verilog/sebt_crc.sv */
`timescale 1ns/1ps
module sebt_crc import sebt_pkg::*; (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic        clr_i,
    input  wire logic        en_i,
    input  wire logic [31:0] data_i,
    output logic [31:0]      crc_o
);
    typedef struct packed {
        logic [31:0] crc;
    } sebt_crc_s;

    sebt_crc_s s_q;
    sebt_crc_s s_d;

    // one word per clock, msb first
    function automatic logic [31:0] crc_step(logic [31:0] c, logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = {r[30:0], 1'b0} ^ (((r[31] ^ d[i]) == 1'b1) ? CRC_POLY : 32'h0);
        end
        return r;
    endfunction

    assign crc_o = s_q.crc;

    always_comb begin
        s_d = s_q;
        if (clr_i) s_d.crc = CRC_SEED;
        else if (en_i) s_d.crc = crc_step(s_q.crc, data_i);
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) s_q <= '{crc: CRC_SEED};
        else s_q <= s_d;
    end
endmodule

/* testbench/sebt_far.sv */
`timescale 1ns/1ps
// ****************
// far end in retimed loopback: returns the tx word stream one cycle later
// ****************
module sebt_far import sebt_pkg::*; (
    input  wire logic        clock_i,
    input  wire logic        rstn_i,
    input  wire logic [31:0] tx_word_i,
    input  wire logic [2:0]  tx_kind_i,
    input  wire logic        flip_i,
    output logic [31:0]      rx_word_o,
    output logic [2:0]       rx_kind_o
);
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_word_o <= 32'h0;
            rx_kind_o <= K_IDLE;
        end else begin
            // crc comes back as the last data word of the frame
            rx_kind_o <= (tx_kind_i == K_CRC) ? K_DATA : tx_kind_i;
            // idle line carries no stale data; flip_i damages bit 0 of every non-idle word while it is high
            rx_word_o <= (tx_kind_i == K_IDLE) ? ~rx_word_o : tx_word_i ^ {31'h0, flip_i};
        end
    end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    import sebt_pkg::*;
    logic        clock_i = 1'b0, rstn_i = 1'b0, pat_vld_i = 1'b0, frame_en_i = 1'b0;
    logic        bist_lpbk_i = 1'b0, bist_xmit_i = 1'b0, oob_reset_i = 1'b0;
    logic        phy_rdy_i = 1'b1, restart_expiry_i = 1'b0, flip = 1'b0;
    logic        code_viol_i = 1'b0, disp_err_i = 1'b0, bit_err_i = 1'b0;
    logic [31:0] pat_data_i = 32'h0;
    logic [31:0] rx_word_i, tx_word_o, byte_err_cnt_o;
    logic [2:0]  rx_kind_i, tx_kind_o;
    logic [3:0]  tally_o;
    logic [15:0] frame_err_cnt_o;
    logic        pat_rdy_o, loop_o, xmit_o, thresh_o, holdoff_o, frame_err_o, soak_pass_o;
    int          n_errors = 0, n_checks = 0, cyc = 0, n_thr = 0, taken = 0;

    sebt_top #(.BURST_N(26'd20), .INTVL_N(33'd500), .SOAK_N(25'd50), .HOLD_N(25'd10))
        sebt_top_i (.*);
    sebt_far sebt_far_i (.clock_i(clock_i), .rstn_i(rstn_i), .tx_word_i(tx_word_o),
        .tx_kind_i(tx_kind_o), .flip_i(flip), .rx_word_o(rx_word_i), .rx_kind_o(rx_kind_i));

    always #20 clock_i = ~clock_i;

    // ****************
    // shared tasks
    // ****************
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // feeds the pattern fifo; cycle ceiling cuts a hang short
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (thresh_o === 1'b1) n_thr <= n_thr + 1;
        if (pat_vld_i && pat_rdy_o) begin
            pat_data_i <= pat_data_i + 32'h1;
            taken <= taken + 1;
        end
        if (cyc == 20000) begin
            $display("ERROR cycle_limit expected %0d seen %0d", 19999, cyc);
            n_errors++;
            close_out();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic burst(input int sel);
        code_viol_i = (sel == 0);
        disp_err_i = (sel == 1);
        bit_err_i = (sel == 2);
        step(1);
        {code_viol_i, disp_err_i, bit_err_i} = 3'h0;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_burst();
        burst(0);
        chk("tally", 1, tally_o);
        chk("byte_errs", 1, byte_err_cnt_o);
        step(5);
        burst(1);
        chk("tally", 1, tally_o);
        chk("byte_errs", 2, byte_err_cnt_o);
        step(25);
        burst(2);
        chk("tally", 2, tally_o);
        chk("byte_errs", 3, byte_err_cnt_o);
        phy_rdy_i = 1'b0;
        step(2);
        phy_rdy_i = 1'b1;
        step(2);
        chk("tally", 0, tally_o);
        $display("test burst done");
    endtask

    task automatic t_thresh();
        repeat (14) begin burst(0); step(24); end
        chk("tally", 14, tally_o);
        chk("thresholds", 0, n_thr);
        burst(0);
        step(3);
        chk("thresholds", 1, n_thr);
        chk("holdoff", 1, holdoff_o);
        burst(1);
        chk("tally", 0, tally_o);
        step(20);
        chk("holdoff", 0, holdoff_o);
        repeat (14) begin burst(2); step(24); end
        chk("thresholds", 1, n_thr);
        burst(0);
        step(3);
        chk("thresholds", 2, n_thr);
        $display("test thresh done");
    endtask

    task automatic t_expiry();
        phy_rdy_i = 1'b0;
        step(2);
        phy_rdy_i = 1'b1;
        restart_expiry_i = 1'b1;
        step(1);
        burst(0);
        step(498);
        chk("tally", 1, tally_o);
        step(1);
        chk("tally", 0, tally_o);
        restart_expiry_i = 1'b0;
        $display("test expiry done");
    endtask

    task automatic t_fifo();
        int i, t0;
        t0 = taken;
        pat_vld_i = 1'b1;
        for (i = 0; i < 100 && pat_rdy_o !== 1'b0; i++) step(1);
        chk("fifo_words", 32, taken - t0);
        $display("test fifo done");
    endtask

    task automatic t_frame(input bit bad);
        int i, nd, na, nc;
        nd = 0;
        na = 0;
        nc = 0;
        frame_en_i = 1'b1;
        step(2);
        chk("sof", K_SOF, tx_kind_o);
        for (i = 0; i < 3000 && tx_kind_o !== K_EOF; i++) begin
            flip = bad && i >= 100 && i < 110 && tx_kind_o === K_DATA;
            if (tx_kind_o === K_DATA) nd++;
            if (tx_kind_o === K_ALIGN) na++;
            if (tx_kind_o === K_CRC) begin
                nc++;
                chk("data_before_crc", 2048, nd);
            end
            step(1);
        end
        flip = 1'b0;
        chk("eof", K_EOF, tx_kind_o);
        chk("data_words", 2048, nd);
        chk("crc_words", 1, nc);
        chk("align_odd", 0, na % 2);
        chk("align_seen", 1, na >= 14);
        // next frame already runs, so the crc verdict lands while soak still counts
        step(2);
        chk("frame_err", bad, frame_err_o);
        step(2);
        chk("frame_errs", bad, frame_err_cnt_o);
        chk("soak_pass", !bad, soak_pass_o);
        frame_en_i = 1'b0;
        oob_reset_i = 1'b1;
        step(1);
        oob_reset_i = 1'b0;
        chk("abort", K_IDLE, tx_kind_o);
        $display("test frame done");
    endtask

    task automatic t_loop();
        logic [31:0] w;
        bist_lpbk_i = 1'b1;
        step(1);
        bist_lpbk_i = 1'b0;
        chk("loop", 1, loop_o);
        frame_en_i = 1'b1;
        bist_xmit_i = 1'b1;
        step(1);
        bist_xmit_i = 1'b0;
        chk("loop", 1, loop_o);
        step(59);
        frame_en_i = 1'b0;
        chk("loop", 1, loop_o);
        chk("soak_pass", 1, soak_pass_o);
        w = rx_word_i;
        step(1);
        chk("relay", w, tx_word_o);
        oob_reset_i = 1'b1;
        step(1);
        oob_reset_i = 1'b0;
        chk("loop", 0, loop_o);
        $display("test loop done");
    endtask

    task automatic t_xmit();
        int i, nd, nf;
        nd = 0;
        nf = 0;
        bist_xmit_i = 1'b1;
        step(1);
        bist_xmit_i = 1'b0;
        chk("xmit", 1, xmit_o);
        for (i = 0; i < 40; i++) begin
            step(1);
            if (tx_kind_o === K_DATA) nd++;
            if (tx_kind_o === K_SOF || tx_kind_o === K_ALIGN) nf++;
        end
        chk("raw_data", 1, nd >= 32);
        chk("raw_framing", 0, nf);
        oob_reset_i = 1'b1;
        step(1);
        oob_reset_i = 1'b0;
        chk("xmit", 0, xmit_o);
        $display("test xmit done");
    endtask

    initial begin
        #30;
        chk("pat_rdy", 1, pat_rdy_o);
        chk("tx_kind", K_IDLE, tx_kind_o);
        chk("tally", 0, tally_o);
        step(1);
        rstn_i = 1'b1;
        step(1);
        t_burst();
        t_thresh();
        t_expiry();
        t_fifo();
        t_frame(1'b0);
        t_frame(1'b1);
        t_loop();
        t_xmit();
        close_out();
    end
endmodule
